// ---- core/strap_config_pkg.sv ----
// Summary of operation
// - strap low disables the local two-wire control port; bus pins are ignored.
// - strap mid enables control port at write address 0x58, read 0x59.
// - strap high enables control port at write address 0x5a, read 0x5b.
// - strap high or floating makes the clock/equalizer pin the serial clock.
// - strap low makes the clock/equalizer pin level select the input equalizer.
// - data/emphasis pin is serial data when enabled, emphasis select when strapped low.
// - emphasis strap low gives 0 dB, high gives 2 dB; mid not recommended.
// - dual-mode sink in TMDS mode ignores emphasis strap and applies none.
// - enable input high leaves power-down; decoding and control port run.
// - enable low holds power-down, ignores inputs, keeps configuration at defaults.
package strap_config_pkg;

    typedef enum logic [1:0] {
        lvl_low,
        lvl_mid,
        lvl_high
    } strap_level_t;

    localparam logic [6:0] ctl_addr_mid = 7'h2c;
    localparam logic [6:0] ctl_addr_high = 7'h2d;
    localparam logic [7:0] ctl_wr_byte_mid = 8'h58;
    localparam logic [7:0] ctl_rd_byte_mid = 8'h59;
    localparam logic [7:0] ctl_wr_byte_high = 8'h5a;
    localparam logic [7:0] ctl_rd_byte_high = 8'h5b;

    localparam logic [1:0] emph_0db = 2'h0;
    localparam logic [1:0] emph_2db = 2'h1;
    localparam logic [1:0] emph_none = 2'h2;

    localparam logic [1:0] eq_reset_code = 2'h0;
    localparam logic [1:0] emph_reset_code = 2'h0;

    localparam int settle_time_ns = 1000;
    localparam int clk_period_ns = 100;
    localparam int settle_cycles = (settle_time_ns + clk_period_ns - 1) / clk_period_ns;

endpackage

// ---- core/strap_level_resolver.sv ----
`timescale 1ns/1ps
module strap_level_resolver
    import strap_config_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // pad sensing
    input wire logic pad_high,
    input wire logic pad_low,
    // result
    output strap_level_t level_q
);
    // an open pad trips both comparators or neither; either way it lands on mid (non-low)
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            level_q <= lvl_high;
        end else if (pad_high && !pad_low) begin
            level_q <= lvl_high;
        end else if (pad_low && !pad_high) begin
            level_q <= lvl_low;
        end else begin
            level_q <= lvl_mid;
        end
    end
endmodule

// ---- core/strap_config_decoder.sv ----
`timescale 1ns/1ps
module strap_config_decoder
    import strap_config_pkg::*;
#(
    // edges the resolvers get to see the pads before the straps are latched
    parameter int settle_len = settle_cycles
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // device enable
    input wire logic device_enable,
    // control-bus strap sensing
    input wire logic control_bus_strap_hi,
    input wire logic control_bus_strap_lo,
    // clock/equalizer pin sensing
    input wire logic clock_or_equalizer_pin_hi,
    input wire logic clock_or_equalizer_pin_lo,
    // data/emphasis pin sensing
    input wire logic data_or_emphasis_pin_hi,
    input wire logic data_or_emphasis_pin_lo,
    // output path state
    input wire logic dual_mode_sink_tmds,
    // decoded results
    output logic powered_down_q,
    output logic config_valid_q,
    output logic ctl_bus_enable_q,
    output logic [6:0] ctl_target_addr_q,
    output logic [7:0] ctl_write_byte_q,
    output logic [7:0] ctl_read_byte_q,
    output logic serial_clock_q,
    output logic serial_data_q,
    output logic [1:0] eq_select_q,
    output logic [1:0] emphasis_q
);
    typedef enum logic [1:0] {
        st_off,
        st_settle,
        st_run
    } dec_state_t;

    localparam int cnt_w = $clog2(settle_len + 1);

    dec_state_t state_q;
    logic [cnt_w-1:0] settle_q;
    strap_level_t ctl_lvl, eq_lvl, emph_lvl;
    strap_level_t ctl_latched_q, emph_latched_q;
    logic settle_last;
    logic live;

    // a zero settle would latch the straps before any resolver has seen its pad
    if (settle_len < 1) begin : g_settle_check
        $error("settle_len must be at least one cycle");
    end

    // wire bytes and 7-bit targets are separate constants; they must stay in step
    if (ctl_wr_byte_mid != {ctl_addr_mid, 1'b0}) begin : g_mid_wr_check
        $error("mid write byte does not match the mid target");
    end
    if (ctl_rd_byte_mid != {ctl_addr_mid, 1'b1}) begin : g_mid_rd_check
        $error("mid read byte does not match the mid target");
    end
    if (ctl_wr_byte_high != {ctl_addr_high, 1'b0}) begin : g_high_wr_check
        $error("high write byte does not match the high target");
    end
    if (ctl_rd_byte_high != {ctl_addr_high, 1'b1}) begin : g_high_rd_check
        $error("high read byte does not match the high target");
    end

    // any non-low level, an open pad included, counts as set
    function automatic logic port_on(input strap_level_t l);
        port_on = (l != lvl_low);
    endfunction

    function automatic logic [1:0] level_code(input strap_level_t l);
        case (l)
            lvl_low: level_code = 2'h0;
            lvl_mid: level_code = 2'h1;
            default: level_code = 2'h2;
        endcase
    endfunction

    strap_level_resolver u_ctl (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pad_high(control_bus_strap_hi),
        .pad_low(control_bus_strap_lo),
        .level_q(ctl_lvl)
    );
    strap_level_resolver u_eq (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pad_high(clock_or_equalizer_pin_hi),
        .pad_low(clock_or_equalizer_pin_lo),
        .level_q(eq_lvl)
    );
    strap_level_resolver u_emph (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pad_high(data_or_emphasis_pin_hi),
        .pad_low(data_or_emphasis_pin_lo),
        .level_q(emph_lvl)
    );

    // decode runs only once the straps are latched and the part is out of power-down
    assign live = rst_n && device_enable && (state_q == st_run);
    assign settle_last = (state_q == st_settle) && (settle_q == cnt_w'(settle_len - 1));

    // power sequencing; a short settle lets resolvers see the pads first
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !device_enable) begin
            state_q <= st_off;
            settle_q <= '0;
        end else begin
            case (state_q)
                st_off: begin
                    state_q <= st_settle;
                    settle_q <= '0;
                end
                st_settle: begin
                    if (settle_last) begin
                        state_q <= st_run;
                    end
                    settle_q <= settle_q + 1'b1;
                end
                default: state_q <= st_run;
            endcase
        end
    end

    // control-bus and emphasis straps captured once at the end of settle, frozen while enabled
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !device_enable) begin
            ctl_latched_q <= lvl_high;
            emph_latched_q <= lvl_low;
        end else if (settle_last) begin
            ctl_latched_q <= ctl_lvl;
            emph_latched_q <= emph_lvl;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n || !device_enable) begin
            powered_down_q <= 1'b1;
            config_valid_q <= 1'b0;
        end else begin
            powered_down_q <= 1'b0;
            config_valid_q <= (state_q == st_run);
        end
    end

    // control port enable; a low strap keeps the port off and the pins free for straps
    always_ff @(posedge sys_clk) begin
        if (!live) begin
            ctl_bus_enable_q <= 1'b0;
        end else if (!port_on(ctl_latched_q)) begin
            ctl_bus_enable_q <= 1'b0;
        end else begin
            ctl_bus_enable_q <= 1'b1;
        end
    end

    // target address; a disabled port parks on the high address as after reset
    always_ff @(posedge sys_clk) begin
        if (!live) begin
            ctl_target_addr_q <= ctl_addr_high;
        end else if (ctl_latched_q == lvl_mid) begin
            ctl_target_addr_q <= ctl_addr_mid;
        end else begin
            ctl_target_addr_q <= ctl_addr_high;
        end
    end

    // address bytes as seen on the wire, write then read
    always_ff @(posedge sys_clk) begin
        if (!live) begin
            ctl_write_byte_q <= ctl_wr_byte_high;
            ctl_read_byte_q <= ctl_rd_byte_high;
        end else if (ctl_latched_q == lvl_mid) begin
            ctl_write_byte_q <= ctl_wr_byte_mid;
            ctl_read_byte_q <= ctl_rd_byte_mid;
        end else begin
            ctl_write_byte_q <= ctl_wr_byte_high;
            ctl_read_byte_q <= ctl_rd_byte_high;
        end
    end

    // serial lines pass only when the port is enabled; idle bus level is high
    always_ff @(posedge sys_clk) begin
        if (!live || !port_on(ctl_latched_q)) begin
            serial_clock_q <= 1'b1;
        end else begin
            serial_clock_q <= port_on(eq_lvl);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!live || !port_on(ctl_latched_q)) begin
            serial_data_q <= 1'b1;
        end else begin
            serial_data_q <= port_on(emph_lvl);
        end
    end

    // equalizer follows pin live in strap mode; serial use holds default
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !device_enable || state_q != st_run) begin
            eq_select_q <= eq_reset_code;
        end else if (ctl_latched_q == lvl_low) begin
            eq_select_q <= level_code(eq_lvl);
        end else begin
            eq_select_q <= eq_reset_code;
        end
    end

    // mid emphasis level is not recommended; treated as 0 dB
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !device_enable || state_q != st_run) begin
            emphasis_q <= emph_reset_code;
        end else if (dual_mode_sink_tmds) begin
            emphasis_q <= emph_none;
        end else if (ctl_latched_q != lvl_low) begin
            emphasis_q <= emph_reset_code;
        end else if (emph_latched_q == lvl_high) begin
            emphasis_q <= emph_2db;
        end else begin
            emphasis_q <= emph_0db;
        end
    end

endmodule

// ---- verif/strap_board.sv ----
`timescale 1ns/1ps
module strap_board (
    // board level: 0 low, 1 mid, 2 high, 3 open
    input wire logic [1:0] level,
    // pad comparators
    output logic hi,
    output logic lo
);
    // an open pad trips both comparators, unlike a driven mid level
    assign hi = (level == 2'h2) || (level == 2'h3);
    assign lo = (level == 2'h0) || (level == 2'h3);
endmodule

// ---- verif/strap_config_checker.sv ----
`timescale 1ns/1ps
module strap_config_checker
    import strap_config_pkg::*;
(
    // clock, reset and inputs
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic device_enable,
    input wire logic clock_or_equalizer_pin_hi,
    input wire logic clock_or_equalizer_pin_lo,
    input wire logic dual_mode_sink_tmds,
    // decoded results
    input wire logic powered_down_q,
    input wire logic config_valid_q,
    input wire logic ctl_bus_enable_q,
    input wire logic [6:0] ctl_target_addr_q,
    input wire logic [7:0] ctl_write_byte_q,
    input wire logic [7:0] ctl_read_byte_q,
    input wire logic serial_clock_q,
    input wire logic serial_data_q,
    input wire logic [1:0] eq_select_q,
    input wire logic [1:0] emphasis_q
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_powerdown_hold: assert property (
        !device_enable |=> powered_down_q && !config_valid_q && !ctl_bus_enable_q)
        else $error("power-down state not held");
    a_leave_powerdown: assert property (
        $rose(device_enable) |=> !powered_down_q ##0 !config_valid_q[*8])
        else $error("power-down exit wrong");
    a_latch_time: assert property (
        $rose(device_enable) ##1 device_enable[*8] ##1 device_enable[*3] |=> config_valid_q)
        else $error("decode not valid in time");
    a_bus_off_idle: assert property (
        config_valid_q && !ctl_bus_enable_q |-> serial_clock_q && serial_data_q)
        else $error("serial lines active while port off");
    a_mid_addr_pair: assert property (
        ctl_bus_enable_q && ctl_target_addr_q == ctl_addr_mid
        |-> {ctl_write_byte_q, ctl_read_byte_q} == 16'h5859) else $error("mid address wrong");
    a_high_addr_pair: assert property (
        ctl_bus_enable_q && ctl_target_addr_q == ctl_addr_high
        |-> {ctl_write_byte_q, ctl_read_byte_q} == 16'h5a5b) else $error("high address wrong");
    a_serial_clk_track: assert property (
        config_valid_q && ctl_bus_enable_q && $past(config_valid_q, 2) |-> eq_select_q == 2'h0
        && serial_clock_q == !($past(clock_or_equalizer_pin_lo, 2)
        && !$past(clock_or_equalizer_pin_hi, 2))) else $error("serial clock not tracking");
    a_mode_stable: assert property (
        config_valid_q && $past(config_valid_q)
        |-> $stable(ctl_bus_enable_q) && $stable(ctl_target_addr_q))
        else $error("pin function changed while enabled");
    a_tmds_no_emph: assert property (
        config_valid_q && dual_mode_sink_tmds && $past(dual_mode_sink_tmds)
        && $past(dual_mode_sink_tmds, 2) |-> emphasis_q == emph_none)
        else $error("emphasis applied in dual-mode sink");
endmodule

bind strap_config_decoder strap_config_checker u_strap_config_checker (.*);

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import strap_config_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic device_enable = 1'b0;
    logic dual_mode_sink_tmds = 1'b0;
    logic [1:0] cb_lvl = 2'h3, eq_lvl = 2'h0, de_lvl = 2'h0;
    logic control_bus_strap_hi, control_bus_strap_lo, clock_or_equalizer_pin_hi;
    logic clock_or_equalizer_pin_lo, data_or_emphasis_pin_hi, data_or_emphasis_pin_lo;
    logic powered_down_q, config_valid_q, ctl_bus_enable_q, serial_clock_q, serial_data_q;
    logic [6:0] ctl_target_addr_q;
    logic [7:0] ctl_write_byte_q, ctl_read_byte_q;
    logic [1:0] eq_select_q, emphasis_q;
    logic [5:0] cases [6] = '{6'h0a, 6'h04, 6'h12, 6'h28, 6'h30, 6'h05};
    int err_count = 0;
    int tests_run = 0;

    always #50 sys_clk = ~sys_clk;
    strap_board u_cb (.level(cb_lvl), .hi(control_bus_strap_hi), .lo(control_bus_strap_lo));
    strap_board u_eq (.level(eq_lvl), .hi(clock_or_equalizer_pin_hi),
        .lo(clock_or_equalizer_pin_lo));
    strap_board u_de (.level(de_lvl), .hi(data_or_emphasis_pin_hi), .lo(data_or_emphasis_pin_lo));
    strap_config_decoder u_strap_config_decoder (.*);

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // straps only count once the device leaves power-down
    task automatic power_up(input logic [1:0] cb, input logic [1:0] eq, input logic [1:0] de);
        int n;
        @(posedge sys_clk);
        device_enable <= 1'b0;
        cb_lvl <= cb;
        eq_lvl <= eq;
        de_lvl <= de;
        repeat (2) @(posedge sys_clk);
        device_enable <= 1'b1;
        for (n = 0; n < 30 && config_valid_q !== 1'b1; n++) @(negedge sys_clk);
        repeat (2) @(negedge sys_clk);
        check("config_valid", config_valid_q, 8'h1);
        check("powered_down", powered_down_q, 8'h0);
    endtask

    task automatic run(input logic [1:0] cb, input logic [1:0] eq, input logic [1:0] de);
        logic en;
        en = (cb != 2'h0);
        power_up(cb, eq, de);
        check("bus_enable", ctl_bus_enable_q, en);
        check("target_addr", ctl_target_addr_q,
            (cb == 2'h2 || !en) ? {1'b0, ctl_addr_high} : {1'b0, ctl_addr_mid});
        check("write_byte", ctl_write_byte_q, (cb == 2'h2 || !en) ? 8'h5a : 8'h58);
        check("read_byte", ctl_read_byte_q, (cb == 2'h2 || !en) ? 8'h5b : 8'h59);
        check("eq_select", eq_select_q, en ? 8'h0 : eq);
        check("serial_clock", serial_clock_q, en ? eq != 2'h0 : 1'b1);
        check("serial_data", serial_data_q, en ? de != 2'h0 : 1'b1);
        if (!en) check("emphasis", emphasis_q, de == 2'h2);
    endtask

    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        foreach (cases[i]) run(cases[i][5:4], cases[i][3:2], cases[i][1:0]);
        power_up(2'h0, 2'h2, 2'h2);
        @(posedge sys_clk);
        cb_lvl <= 2'h2;
        de_lvl <= 2'h0;
        eq_lvl <= 2'h1;
        repeat (3) @(negedge sys_clk);
        check("latched_bus", ctl_bus_enable_q, 8'h0);
        check("latched_emph", emphasis_q, 8'h1);
        check("eq_live", eq_select_q, 8'h1);
        @(posedge sys_clk);
        dual_mode_sink_tmds <= 1'b1;
        repeat (3) @(negedge sys_clk);
        check("tmds_emph", emphasis_q, 8'h2);
        @(posedge sys_clk);
        device_enable <= 1'b0;
        repeat (2) @(negedge sys_clk);
        check("pd_state", powered_down_q, 8'h1);
        check("pd_valid", config_valid_q, 8'h0);
        check("pd_bus", ctl_bus_enable_q, 8'h0);
        close_out();
    end

    initial begin
        repeat (1000) @(posedge sys_clk);
        err_count++;
        close_out();
    end
endmodule
